// File: rtl/flash_cmd_pkg.sv
// Constants for the remote flash-store command handler.
// Assumes command fields arrive already parsed from the addressed frame: code and options byte-wide, block, offset and count 16-bit.
package flash_cmd_pkg;
  // Request command codes and reply flag
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
  localparam logic [7:0] CMD_READ = 8'h04;
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_VERIFY_INSTALL = 8'h06;
  localparam logic [7:0] REPLY_FLAG = 8'h80;
  // Result status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_GENERAL = 8'h01;
  localparam logic [7:0] ST_BEYOND_LAST = 8'h03;
  localparam logic [7:0] ST_CROSS_BLOCK = 8'h04;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'h06;
  localparam logic [7:0] ST_BUSY = 8'h07;
  localparam logic [7:0] ST_READ_FAIL = 8'h30;
  localparam logic [7:0] ST_READ_TOO_LONG = 8'h31;
  localparam logic [7:0] ST_INCOMPAT = 8'h41;
  localparam logic [7:0] ST_CORRUPT = 8'h42;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_GEOM = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MAXREAD = 4'hC;
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int GEOM_COUNT_LSB = 0;
  localparam int GEOM_SIZE_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LAST_LSB = 8;
  localparam int STAT_CMD_LSB = 16;
  // Reset values and default buffer depth
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [15:0] DEF_BLOCK_COUNT = 16'h0040;
  localparam logic [15:0] DEF_BLOCK_SIZE = 16'h0200;
  localparam logic [15:0] DEF_MAX_READ = 16'h0040;
  localparam int DEF_BUF_DEPTH = 64;
endpackage

// File: rtl/flash_cmd_handler.sv
// Command handler for the general flash store: write/erase-then-write replies,
// read with payload, firmware verify and verify-and-install.
// Assumes an external flash engine and image verifier, a frame layer that
// parses requests and serialises replies, and a classic Wishbone master.
`timescale 1ns/1ns

// Operation
// R01: Write replies use code 0x82, erase-then-write replies use 0x83.
// R02: Reply status is 0 on success, a nonzero error code otherwise.
// R03: Write, erase-then-write and read replies echo block index and byte offset.
// R04: Write and erase-then-write replies carry byte count 0 and no payload.
// R05: Replies go to the source endpoint named in the request.
// R06: Requester encodes read as code 0x04.
// R07: Requester sets read option flags to 0.
// R08: Read request names block index and starting byte offset.
// R09: Read stays in one block; offset plus count within block size.
// R10: Request frame never exceeds the device maximum payload size.
// R11: Read requests carry no payload.
// R12: Read is answered with code 0x84.
// R13: Read reply carries the bytes read, count equals payload length.
// R14: Requester encodes verify as 0x05 and verify-and-install as 0x06.
// R15: Verify requests carry zero options, block, offset, count, no payload.
// R16: Both verify commands check the stored image and report in status.
// R17: Verify-and-install with valid image replies first, then resets.
// R18: Radio reception may stall while an image is verified.
// R19: Block-crossing access gives 0x04, block beyond last gives 0x03.
// R20: Unknown command gives 0x06, command while busy gives 0x07.
// R21: Read longer than one reply gives 0x31, flash read failure 0x30.
// R22: Incompatible image gives 0x41, corrupted image gives 0x42.
// R23: Reply code is request code plus 0x80.
module flash_cmd_handler
  import flash_cmd_pkg::*;
#(
  parameter int BUF_DEPTH = DEF_BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Parsed request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [7:0] reqSrcEndpoint,
  input wire logic [7:0] commandCodeField,
  input wire logic [7:0] optionFlagsField,
  input wire logic [15:0] blockIndexField,
  input wire logic [15:0] byteOffsetField,
  input wire logic [15:0] byteCountField,
  // Reply header
  output logic rspValid,
  input wire logic rspReady,
  output logic [7:0] rspDstEndpoint,
  output logic [7:0] rspCommandCode,
  output logic [7:0] rspResultStatus,
  output logic [15:0] rspBlockIndex,
  output logic [15:0] rspByteOffset,
  output logic [15:0] rspByteCount,
  // Reply payload bytes
  output logic payValid,
  input wire logic payReady,
  output logic [7:0] payByte,
  // Flash engine
  output logic flashRdReq,
  output logic [31:0] flashAddr,
  input wire logic flashRdAck,
  input wire logic flashRdErr,
  input wire logic [7:0] flashRdData,
  output logic flashWrReq,
  output logic flashWrErase,
  input wire logic flashWrDone,
  input wire logic [7:0] flashWrStatus,
  // Image verifier and install
  output logic verReq,
  input wire logic verDone,
  input wire logic verCompatible,
  input wire logic verIntact,
  output logic rxBlocked,
  output logic installReset
);

  localparam int AW = $clog2(BUF_DEPTH);

  typedef enum logic [3:0] {
    S_IDLE, S_CHECK, S_READ, S_WRITE, S_VERIFY, S_HDR, S_PAY, S_INSTALL
  } state_t;

  state_t state_reg, state_next;
  logic enable_reg, enable_next;
  logic [15:0] blkCount_reg, blkCount_next;
  logic [15:0] blkSize_reg, blkSize_next;
  logic [15:0] maxRead_reg, maxRead_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [7:0] lastStatus_reg, lastStatus_next;
  logic [7:0] ep_reg, ep_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [15:0] blk_reg, blk_next;
  logic [15:0] off_reg, off_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0] status_reg, status_next;
  logic [15:0] idx_reg, idx_next;
  logic [31:0] addr_reg, addr_next;
  logic rejPend_reg, rejPend_next;
  logic [7:0] rejEp_reg, rejEp_next;
  logic [7:0] rejCmd_reg, rejCmd_next;
  logic [15:0] rejBlk_reg, rejBlk_next;
  logic [15:0] rejOff_reg, rejOff_next;
  logic [7:0] buffer [BUF_DEPTH];

  logic busAccess, reqTake, isRead, isWriteKind, isVerify, tooFar, tooLong;
  logic [16:0] endPos;
  logic [31:0] blockBase;

  assign busAccess = wb_cyc_i && wb_stb_i && !ack_reg;
  // A request arriving while busy is held for one busy reply; the port stalls
  // only while that single slot is occupied.
  assign reqReady = !rejPend_reg; // see R20
  assign reqTake = reqValid && reqReady;
  assign isRead = cmd_reg == CMD_READ;
  assign isWriteKind = cmd_reg == CMD_WRITE || cmd_reg == CMD_ERASE_WRITE;
  assign isVerify = cmd_reg == CMD_VERIFY || cmd_reg == CMD_VERIFY_INSTALL;
  assign endPos = {1'b0, off_reg} + {1'b0, cnt_reg};
  assign tooFar = endPos > {1'b0, blkSize_reg};
  assign tooLong = cnt_reg > maxRead_reg || {16'h0000, cnt_reg} > 32'(BUF_DEPTH);
  assign blockBase = 32'(blk_reg) * 32'(blkSize_reg);

  assign rspValid = state_reg == S_HDR;
  assign rspDstEndpoint = ep_reg; // see R05
  assign rspCommandCode = cmd_reg | REPLY_FLAG; // see R01 see R12 see R23
  assign rspResultStatus = status_reg;
  assign rspBlockIndex = blk_reg; // see R03
  assign rspByteOffset = off_reg;
  assign rspByteCount = (isRead && status_reg == ST_OK) ? cnt_reg : 16'h0000; // see R04 see R13
  assign payValid = state_reg == S_PAY;
  assign payByte = buffer[idx_reg[AW-1:0]];
  assign flashRdReq = state_reg == S_READ;
  assign flashAddr = addr_reg;
  assign flashWrReq = state_reg == S_WRITE;
  assign flashWrErase = cmd_reg == CMD_ERASE_WRITE;
  assign verReq = state_reg == S_VERIFY;
  assign rxBlocked = state_reg == S_VERIFY; // see R18
  assign installReset = state_reg == S_INSTALL;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Register file: one-cycle ack, unmapped reads return zero
  always_comb begin
    ack_next = busAccess;
    rdat_next = 32'h0000_0000;
    enable_next = enable_reg;
    blkCount_next = blkCount_reg;
    blkSize_next = blkSize_reg;
    maxRead_next = maxRead_reg;
    if (busAccess && wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: begin
          if (wb_sel_i[0]) begin
            enable_next = wb_dat_i[CTRL_ENABLE_BIT];
          end
        end
        REG_GEOM: begin
          if (wb_sel_i[0]) blkCount_next[7:0] = wb_dat_i[GEOM_COUNT_LSB +: 8];
          if (wb_sel_i[1]) blkCount_next[15:8] = wb_dat_i[GEOM_COUNT_LSB + 8 +: 8];
          if (wb_sel_i[2]) blkSize_next[7:0] = wb_dat_i[GEOM_SIZE_LSB +: 8];
          if (wb_sel_i[3]) blkSize_next[15:8] = wb_dat_i[GEOM_SIZE_LSB + 8 +: 8];
        end
        REG_MAXREAD: begin
          if (wb_sel_i[0]) maxRead_next[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) maxRead_next[15:8] = wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end else if (busAccess) begin
      case (wb_adr_i)
        REG_CTRL: rdat_next[CTRL_ENABLE_BIT] = enable_reg;
        REG_GEOM: rdat_next = {blkSize_reg, blkCount_reg};
        REG_STATUS: begin
          rdat_next[STAT_BUSY_BIT] = state_reg != S_IDLE;
          rdat_next[STAT_LAST_LSB +: 8] = lastStatus_reg;
          rdat_next[STAT_CMD_LSB +: 8] = cmd_reg;
        end
        REG_MAXREAD: rdat_next = {16'h0000, maxRead_reg};
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      enable_reg <= CTRL_ENABLE_RESET;
      blkCount_reg <= DEF_BLOCK_COUNT;
      blkSize_reg <= DEF_BLOCK_SIZE;
      maxRead_reg <= DEF_MAX_READ;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      enable_reg <= enable_next;
      blkCount_reg <= blkCount_next;
      blkSize_reg <= blkSize_next;
      maxRead_reg <= maxRead_next;
    end
  end

  // Command sequencer
  always_comb begin
    state_next = state_reg;
    ep_next = ep_reg;
    cmd_next = cmd_reg;
    blk_next = blk_reg;
    off_next = off_reg;
    cnt_next = cnt_reg;
    status_next = status_reg;
    idx_next = idx_reg;
    addr_next = addr_reg;
    lastStatus_next = lastStatus_reg;
    rejPend_next = rejPend_reg;
    rejEp_next = rejEp_reg;
    rejCmd_next = rejCmd_reg;
    rejBlk_next = rejBlk_reg;
    rejOff_next = rejOff_reg;
    if (reqTake && state_reg != S_IDLE) begin
      rejPend_next = 1'b1; // see R20
      rejEp_next = reqSrcEndpoint;
      rejCmd_next = commandCodeField;
      rejBlk_next = blockIndexField;
      rejOff_next = byteOffsetField;
    end
    case (state_reg)
      S_IDLE: begin
        if (rejPend_reg) begin
          rejPend_next = 1'b0;
          ep_next = rejEp_reg;
          cmd_next = rejCmd_reg;
          blk_next = rejBlk_reg;
          off_next = rejOff_reg;
          cnt_next = 16'h0000;
          status_next = ST_BUSY; // see R20
          state_next = S_HDR;
        end else if (reqTake) begin
          ep_next = reqSrcEndpoint; // see R05
          cmd_next = commandCodeField;
          blk_next = blockIndexField; // see R03
          off_next = byteOffsetField;
          cnt_next = byteCountField;
          state_next = S_CHECK;
        end
      end
      S_CHECK: begin
        idx_next = 16'h0000;
        addr_next = blockBase + 32'(off_reg);
        status_next = ST_OK; // see R02
        state_next = S_HDR;
        if (!enable_reg) begin
          status_next = ST_GENERAL;
        end else if (isRead || isWriteKind) begin
          if (blk_reg >= blkCount_reg) begin
            status_next = ST_BEYOND_LAST; // see R19
          end else if (tooFar) begin
            status_next = ST_CROSS_BLOCK; // see R19
          end else if (isRead && tooLong) begin
            status_next = ST_READ_TOO_LONG; // see R21
          end else if (isWriteKind) begin
            state_next = S_WRITE;
          end else if (cnt_reg != 16'h0000) begin
            state_next = S_READ;
          end
        end else if (isVerify) begin
          state_next = S_VERIFY; // see R16
        end else begin
          status_next = ST_UNKNOWN_CMD; // see R20
        end
      end
      S_READ: begin
        if (flashRdAck) begin
          idx_next = idx_reg + 16'h0001;
          addr_next = addr_reg + 32'h0000_0001;
          if (flashRdErr) begin
            status_next = ST_READ_FAIL; // see R21
            state_next = S_HDR;
          end else if (idx_reg + 16'h0001 == cnt_reg) begin
            state_next = S_HDR;
          end
        end
      end
      S_WRITE: begin
        if (flashWrDone) begin
          status_next = flashWrStatus; // see R02
          state_next = S_HDR;
        end
      end
      S_VERIFY: begin
        if (verDone) begin
          status_next = !verCompatible ? ST_INCOMPAT : (!verIntact ? ST_CORRUPT : ST_OK); // see R22
          state_next = S_HDR;
        end
      end
      S_HDR: begin
        idx_next = 16'h0000;
        if (rspReady) begin
          lastStatus_next = status_reg;
          if (isRead && status_reg == ST_OK && cnt_reg != 16'h0000) begin
            state_next = S_PAY; // see R13
          end else if (cmd_reg == CMD_VERIFY_INSTALL && status_reg == ST_OK) begin
            state_next = S_INSTALL; // see R17
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      S_PAY: begin
        if (payReady) begin
          idx_next = idx_reg + 16'h0001;
          if (idx_reg + 16'h0001 == cnt_reg) begin
            state_next = S_IDLE;
          end
        end
      end
      S_INSTALL: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      ep_reg <= 8'h00;
      cmd_reg <= 8'h00;
      blk_reg <= 16'h0000;
      off_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      status_reg <= 8'h00;
      idx_reg <= 16'h0000;
      addr_reg <= 32'h0000_0000;
      lastStatus_reg <= 8'h00;
      rejPend_reg <= 1'b0;
      rejEp_reg <= 8'h00;
      rejCmd_reg <= 8'h00;
      rejBlk_reg <= 16'h0000;
      rejOff_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      ep_reg <= ep_next;
      cmd_reg <= cmd_next;
      blk_reg <= blk_next;
      off_reg <= off_next;
      cnt_reg <= cnt_next;
      status_reg <= status_next;
      idx_reg <= idx_next;
      addr_reg <= addr_next;
      lastStatus_reg <= lastStatus_next;
      rejPend_reg <= rejPend_next;
      rejEp_reg <= rejEp_next;
      rejCmd_reg <= rejCmd_next;
      rejBlk_reg <= rejBlk_next;
      rejOff_reg <= rejOff_next;
    end
  end

  // Read bytes are buffered so the status is final before the header leaves
  always_ff @(posedge clk) begin
    if (state_reg == S_READ && flashRdAck && !flashRdErr) begin
      buffer[idx_reg[AW-1:0]] <= flashRdData; // see R13
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence hdrTaken;
    rspValid && rspReady;
  endsequence
  sequence readHdrWithData;
    hdrTaken and (isRead && status_reg == ST_OK && cnt_reg != 16'h0000);
  endsequence

  AST_WRITE_CODES: assert property (rspValid && isWriteKind |-> // see R01
    rspCommandCode == (cmd_reg == CMD_WRITE ? 8'h82 : 8'h83))
    else $error("write reply code wrong");
  AST_WRITE_EMPTY: assert property (rspValid && isWriteKind |-> rspByteCount == 16'h0000) // see R04
    else $error("write reply count not zero");
  AST_READ_PAYLOAD: assert property (readHdrWithData |=> payValid[*1] ##0 // see R13
    (rspByteCount == cnt_reg))
    else $error("read payload did not follow header");
  AST_ECHO_FIELDS: assert property (reqTake && state_reg == S_IDLE && !rejPend_reg |=> // see R03
    blk_reg == $past(blockIndexField) && off_reg == $past(byteOffsetField))
    else $error("block or offset not echoed");
  AST_ENDPOINT: assert property (reqTake && state_reg == S_IDLE && !rejPend_reg |=> // see R05
    rspDstEndpoint == $past(reqSrcEndpoint))
    else $error("reply endpoint differs from source");
  AST_BEYOND_LAST: assert property (state_reg == S_CHECK && enable_reg && isRead && // see R19
    blk_reg >= blkCount_reg |=> rspValid && rspResultStatus == ST_BEYOND_LAST)
    else $error("block beyond last not rejected");
  AST_BUSY_REPLY: assert property (reqTake && state_reg != S_IDLE |=> rejPend_reg) // see R20
    else $error("busy request not held");
  AST_INSTALL_ORDER: assert property (installReset |-> $past(rspValid && rspReady) && // see R17
    cmd_reg == CMD_VERIFY_INSTALL && $past(status_reg) == ST_OK)
    else $error("install reset without prior good reply");
  AST_QUIET: assert property (rxBlocked && !verDone |=> rxBlocked) // see R18
    else $error("reception not blocked while verifying");
  AST_PAIRING: assert property (hdrTaken |-> rspCommandCode == (cmd_reg | 8'h80)) // see R23
    else $error("reply code not paired");

endmodule

// File: dv/flash_store_model.sv
// Behavioural flash engine and image verifier facing the command handler.
// Assumes level requests held until the matching one-cycle answer.
`timescale 1ns/1ns
module flash_store_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Scenario controls
  input wire logic slow,
  input wire logic rdFail,
  input wire logic [7:0] wrStatus,
  input wire logic imgCompat,
  input wire logic imgIntact,
  // Handler side
  input wire logic flashRdReq,
  input wire logic [31:0] flashAddr,
  input wire logic flashWrReq,
  input wire logic verReq,
  output logic flashRdAck,
  output logic flashRdErr,
  output logic [7:0] flashRdData,
  output logic flashWrDone,
  output logic [7:0] flashWrStatus,
  output logic verDone,
  output logic verCompatible,
  output logic verIntact
);
  logic [3:0] waitReg;
  logic [3:0] waitNext;
  logic hit;
  // Slow mode stands in for the long verify gap while reception is stalled
  assign hit = (waitReg == (slow ? 4'h5 : 4'h0));
  always_comb begin
    waitNext = waitReg + 4'h1;
    if (hit || !(flashRdReq || flashWrReq || verReq)) begin
      waitNext = 4'h0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitReg <= 4'h0;
    end else begin
      waitReg <= waitNext;
    end
  end
  assign flashRdAck = flashRdReq && hit;
  assign flashRdErr = flashRdAck && rdFail;
  // Outside an answer the read data carries a moving pattern and the other lines the inverted answer, so stale data never matches
  assign flashRdData = flashRdAck ? (flashAddr[7:0] ^ 8'h5A) : {waitReg, ~waitReg};
  assign flashWrDone = flashWrReq && hit;
  assign flashWrStatus = flashWrDone ? wrStatus : ~wrStatus;
  assign verDone = verReq && hit;
  assign verCompatible = verDone ? imgCompat : ~imgCompat;
  assign verIntact = verDone ? imgIntact : ~imgIntact;
endmodule

// File: dv/testbench.sv
// Self-checking bench for the flash-store command handler.
// Assumes the flash and verifier model answers every level request.
`timescale 1ns/1ns
module testbench
  import flash_cmd_pkg::*;
;
  logic clk, resetn, cyc, stb, we, ack;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q, flashAddr;
  logic reqValid, reqReady, rspValid, rspReady, payValid, payReady;
  logic [7:0] srcEp, cmdCode, dstEp, rspCmd, rspSt, payByte, flashRdData, flashWrStatus, wrStatus;
  logic [15:0] blk, off, cnt, rspBlk, rspOff, rspCnt;
  logic flashRdReq, flashRdAck, flashRdErr, flashWrReq, flashWrErase, flashWrDone;
  logic verReq, verDone, verCompatible, verIntact, rxBlocked, installReset;
  logic slow, rdFail, imgCompat, imgIntact, eraseSeen;
  int fails, nChecks, n;

  flash_cmd_handler dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .reqValid(reqValid), .reqReady(reqReady), .reqSrcEndpoint(srcEp),
    .commandCodeField(cmdCode), .optionFlagsField(8'h00), .blockIndexField(blk),
    .byteOffsetField(off), .byteCountField(cnt), .rspValid(rspValid), .rspReady(rspReady),
    .rspDstEndpoint(dstEp), .rspCommandCode(rspCmd), .rspResultStatus(rspSt),
    .rspBlockIndex(rspBlk), .rspByteOffset(rspOff), .rspByteCount(rspCnt),
    .payValid(payValid), .payReady(payReady), .payByte(payByte), .flashRdReq(flashRdReq),
    .flashAddr(flashAddr), .flashRdAck(flashRdAck), .flashRdErr(flashRdErr),
    .flashRdData(flashRdData), .flashWrReq(flashWrReq), .flashWrErase(flashWrErase),
    .flashWrDone(flashWrDone), .flashWrStatus(flashWrStatus), .verReq(verReq),
    .verDone(verDone), .verCompatible(verCompatible), .verIntact(verIntact),
    .rxBlocked(rxBlocked), .installReset(installReset));

  flash_store_model far (.clk(clk), .resetn(resetn), .slow(slow), .rdFail(rdFail),
    .wrStatus(wrStatus), .imgCompat(imgCompat), .imgIntact(imgIntact),
    .flashRdReq(flashRdReq), .flashAddr(flashAddr), .flashWrReq(flashWrReq),
    .verReq(verReq), .flashRdAck(flashRdAck), .flashRdErr(flashRdErr),
    .flashRdData(flashRdData), .flashWrDone(flashWrDone), .flashWrStatus(flashWrStatus),
    .verDone(verDone), .verCompatible(verCompatible), .verIntact(verIntact));

  // Erase flag as the engine saw it when it finished the last write
  always @(posedge clk) begin
    if (flashWrDone) eraseSeen <= flashWrErase;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (fails == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait on a settled level, sampled half a cycle after the edge
  // Selector 0 is request ready, 1 reply valid, 2 payload valid
  task automatic waitHigh(input int sel);
    logic s;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      s = (sel == 0) ? reqReady : ((sel == 1) ? rspValid : payValid);
    end while (s !== 1'b1 && n < 2000);
    if (n >= 2000) fails++;
  endtask

  // Request held until the rising edge that sees ack; data taken and released there
  task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 2000);
    if (n >= 2000) fails++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Requests keep options zero and carry no payload; verify fields are zero
  task automatic sendReq(input logic [7:0] c, input logic [15:0] b, o, k);
    @(posedge clk);
    reqValid <= 1'b1;
    cmdCode <= c;
    blk <= b;
    off <= o;
    cnt <= k;
    srcEp <= c ^ 8'h30;
    waitHigh(0);
    @(posedge clk);
    reqValid <= 1'b0;
  endtask

  task automatic handshake(input bit pay);
    @(posedge clk);
    if (pay) payReady <= 1'b1;
    else rspReady <= 1'b1;
    @(posedge clk);
    if (pay) payReady <= 1'b0;
    else rspReady <= 1'b0;
  endtask

  task automatic getRsp(input logic [7:0] c, input logic [15:0] b, o, input logic [7:0] st,
                        input logic [15:0] k);
    waitHigh(1);
    chk({dstEp, rspCmd, 8'h00, rspSt}, {c ^ 8'h30, c + 8'h80, 8'h00, st});
    chk({rspBlk, rspOff}, {b, o});
    chk({16'h0, rspCnt}, {16'h0, k});
    handshake(1'b0);
    for (int i = 0; i < k; i++) begin
      waitHigh(2);
      chk({24'h0, payByte}, {24'h0, (o[7:0] + i[7:0]) ^ 8'h5A});
      handshake(1'b1);
    end
    @(negedge clk);
    chk({31'h0, payValid}, 32'h0);
  endtask

  task automatic doCmd(input logic [7:0] c, input logic [15:0] b, o, k, input logic [7:0] st,
                       input logic [15:0] rk);
    sendReq(c, b, o, k);
    getRsp(c, b, o, st, rk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    fails++;
    test_done;
  end

  initial begin
    {resetn, cyc, stb, we, reqValid, rspReady, payReady, slow, rdFail} = '0;
    {imgCompat, imgIntact} = 2'b11;
    {adr, wdat, srcEp, cmdCode, blk, off, cnt, wrStatus} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wbXfer(1'b0, REG_GEOM, 32'h0);
    chk(q, 32'h02000040);
    wbXfer(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    doCmd(CMD_WRITE, 16'h0016, 16'h0000, 16'h000F, ST_OK, 16'h0);
    chk({31'h0, eraseSeen}, 32'h0);
    wrStatus <= 8'h20;
    doCmd(CMD_ERASE_WRITE, 16'h0016, 16'h0004, 16'h0008, 8'h20, 16'h0);
    chk({31'h0, eraseSeen}, 32'h1);
    doCmd(CMD_WRITE, 16'h0001, 16'h01F8, 16'h0010, ST_CROSS_BLOCK, 16'h0);
    slow <= 1'b1;
    doCmd(CMD_READ, 16'h0016, 16'h0010, 16'h0004, ST_OK, 16'h0004);
    slow <= 1'b0;
    doCmd(CMD_READ, 16'h003F, 16'h01FC, 16'h0004, ST_OK, 16'h0004);
    doCmd(CMD_READ, 16'h0016, 16'h01FD, 16'h0004, ST_CROSS_BLOCK, 16'h0);
    doCmd(CMD_READ, 16'h0040, 16'h0000, 16'h0001, ST_BEYOND_LAST, 16'h0);
    doCmd(CMD_READ, 16'h0003, 16'h0000, 16'h0040, ST_OK, 16'h0040);
    doCmd(CMD_READ, 16'h0003, 16'h0000, 16'h0041, ST_READ_TOO_LONG, 16'h0);
    rdFail <= 1'b1;
    doCmd(CMD_READ, 16'h0016, 16'h0000, 16'h0002, ST_READ_FAIL, 16'h0);
    rdFail <= 1'b0;
    doCmd(8'h01, 16'h0, 16'h0, 16'h0, ST_UNKNOWN_CMD, 16'h0);
    doCmd(8'h07, 16'h0, 16'h0, 16'h0, ST_UNKNOWN_CMD, 16'h0);
    for (int k = 0; k < 3; k++) begin
      imgCompat <= (k != 0);
      imgIntact <= (k == 2);
      doCmd(CMD_VERIFY, 16'h0, 16'h0, 16'h0, (k == 0) ? ST_INCOMPAT :
            ((k == 1) ? ST_CORRUPT : ST_OK), 16'h0);
    end
    // A second request while verify runs waits in the slot and is refused as busy
    slow <= 1'b1;
    sendReq(CMD_VERIFY, 16'h0, 16'h0, 16'h0);
    sendReq(CMD_READ, 16'h0005, 16'h0007, 16'h0003);
    getRsp(CMD_VERIFY, 16'h0, 16'h0, ST_OK, 16'h0);
    getRsp(CMD_READ, 16'h0005, 16'h0007, ST_BUSY, 16'h0);
    slow <= 1'b0;
    wbXfer(1'b1, REG_CTRL, 32'h0);
    doCmd(CMD_READ, 16'h0, 16'h0, 16'h0001, ST_GENERAL, 16'h0);
    wbXfer(1'b1, REG_CTRL, 32'h1);
    imgIntact <= 1'b0;
    doCmd(CMD_VERIFY_INSTALL, 16'h0, 16'h0, 16'h0, ST_CORRUPT, 16'h0);
    chk({31'h0, installReset}, 32'h0);
    imgIntact <= 1'b1;
    doCmd(CMD_VERIFY_INSTALL, 16'h0, 16'h0, 16'h0, ST_OK, 16'h0);
    n = 0;
    while (installReset !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, installReset}, 32'h1);
    wbXfer(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h00060000);
    test_done;
  end
endmodule
